/* File: rtl/sfd_dev.sv */
// flash end: decodes program/erase/suspend transactions
// How it works
// - 12h: four address bytes, page data, needs enable
// - 20h/21h erase 4KB sector, needs enable
// - D8h/DCh erase 256KB sector, needs enable
// - 60h or C7h erase whole array, enabled
// - D0h plus address: check last erase status
// - 5Dh plus address: report sector erase count
// - 75h suspends program, erase or integrity check
// - 85h/B0h suspend program or erase only
`timescale 1ns/1ps
module sfd_dev
	import sfd_pkg::*;
#(
	parameter int PAGE = PAGE_BYTES
) (
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	sfd_if.dev               link,
	output logic             op_start,
	output sfd_pkg::sfd_op_t op_kind,
	output logic [31:0]      op_addr,
	output logic             susp_all,
	output logic             susp_pe,
	output logic [7:0]       wr_data,
	output logic             wr_valid,
	input  wire logic        wr_ready,
	output logic             wr_drop
);
	import sfd_pkg::*;

	sfd_st_t       st_r;
	logic [2:0]    bit_r;
	logic [7:0]    sh_r;
	logic [2:0]    abytes_r;
	logic [2:0]    acnt_r;
	logic [31:0]   addr_r;
	sfd_op_t       kind_r;
	logic          wel_r;
	logic          sck_d_r;
	logic          cs_d_r;
	logic          rise;
	logic          end_frame;
	logic [7:0]    byte_now;
	logic          byte_done;
	logic [9:0]    dcnt_r;
	logic          fifo_in_valid;
	logic          fifo_in_ready;
	logic          op_start_r;
	sfd_op_t       op_kind_r;
	logic [31:0]   op_addr_r;
	logic          susp_all_r;
	logic          susp_pe_r;
	logic          wr_drop_r;

	function automatic sfd_op_t dec(input logic [7:0] op);
		case (op)
			OP_WREN:                 dec = SFD_OP_WREN;
			OP_PP4:                  dec = SFD_OP_PROG;
			OP_SE4K3, OP_SE4K4:      dec = SFD_OP_SE4K;
			OP_SE256K3, OP_SE256K4:  dec = SFD_OP_SE256;
			OP_CE_A, OP_CE_B:        dec = SFD_OP_CHIP;
			OP_EVAL3:                dec = SFD_OP_EVAL;
			OP_ECNT3:                dec = SFD_OP_ECNT;
			OP_SUSP_ALL:             dec = SFD_OP_SUSPA;
			OP_SUSP_A, OP_SUSP_B:    dec = SFD_OP_SUSPP;
			default:                 dec = SFD_OP_NONE;
		endcase
	endfunction

	function automatic logic [2:0] alen(input logic [7:0] op);
		case (op)
			OP_PP4, OP_SE4K4, OP_SE256K4: alen = ADDR_BYTES4;
			OP_SE4K3, OP_SE256K3, OP_EVAL3, OP_ECNT3: alen = ADDR_BYTES3;
			default:                  alen = ADDR_BYTES0;
		endcase
	endfunction

	function automatic logic needs_wel(input sfd_op_t k);
		needs_wel = (k == SFD_OP_PROG) || (k == SFD_OP_SE4K) ||
			(k == SFD_OP_SE256) || (k == SFD_OP_CHIP);
	endfunction

	// sck and cs sampled on sys_clk; sck must be well below sys_clk/4
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			sck_d_r <= 1'b0;
			cs_d_r  <= 1'b1;
		end else begin
			sck_d_r <= link.sck;
			cs_d_r  <= link.cs_b;
		end
	end

	assign rise      = link.sck && !sck_d_r && !link.cs_b;
	assign end_frame = link.cs_b && !cs_d_r;
	assign byte_now  = {sh_r[6:0], link.sdi};
	assign byte_done = rise && (bit_r == BIT_LAST);

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			bit_r <= '0;
			sh_r  <= '0;
		end else if (link.cs_b) begin
			bit_r <= '0;
		end else if (rise) begin
			sh_r  <= byte_now;
			bit_r <= bit_r + 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r     <= SFD_IDLE;
			kind_r   <= SFD_OP_NONE;
			abytes_r <= '0;
			acnt_r   <= '0;
			addr_r   <= '0;
		end else if (link.cs_b) begin
			st_r <= SFD_IDLE;
		end else begin
			case (st_r)
				SFD_IDLE: begin
					st_r   <= SFD_OPC;
					acnt_r <= '0;
					addr_r <= '0;
				end
				SFD_OPC: if (byte_done) begin
					kind_r   <= dec(byte_now);
					abytes_r <= alen(byte_now);
					st_r     <= (alen(byte_now) != ADDR_BYTES0) ?
						SFD_ADR : SFD_DAT;
				end
				SFD_ADR: if (byte_done) begin
					addr_r <= {addr_r[23:0], byte_now};
					acnt_r <= acnt_r + 1'b1;
					if (acnt_r + 1'b1 == abytes_r)
						st_r <= SFD_DAT;
				end
				SFD_DAT: st_r <= SFD_DAT;
				default: st_r <= SFD_IDLE;
			endcase
		end
	end

	// write enable latch: set by enable frame, spent by a granted op
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			wel_r <= 1'b0;
		else if (end_frame && st_r == SFD_DAT) begin
			if (kind_r == SFD_OP_WREN)
				wel_r <= 1'b1;
			else if (needs_wel(kind_r))
				wel_r <= 1'b0;
		end
	end

	// page data streamed while enabled, page wraps
	assign fifo_in_valid = byte_done && st_r == SFD_DAT &&
		kind_r == SFD_OP_PROG && wel_r;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			dcnt_r    <= '0;
			wr_drop_r <= 1'b0;
		end else begin
			if (link.cs_b)
				dcnt_r <= '0;
			else if (fifo_in_valid)
				dcnt_r <= (dcnt_r == 10'(PAGE - 1)) ? '0 : dcnt_r + 1'b1;
			// overflow when the array side stalls too long
			wr_drop_r <= fifo_in_valid && !fifo_in_ready;
		end
	end

	sfd_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.sys_clk   (sys_clk),
		.rst_b     (rst_b),
		.in_data   (byte_now),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.out_data  (wr_data),
		.out_valid (wr_valid),
		.out_ready (wr_ready)
	);

	// operations launch at frame end only, after full decode
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			op_start_r <= 1'b0;
			op_kind_r  <= SFD_OP_NONE;
			op_addr_r  <= '0;
			susp_all_r <= 1'b0;
			susp_pe_r  <= 1'b0;
		end else begin
			op_start_r <= 1'b0;
			susp_all_r <= 1'b0;
			susp_pe_r  <= 1'b0;
			if (end_frame && st_r == SFD_DAT) begin
				case (kind_r)
					SFD_OP_PROG, SFD_OP_SE4K, SFD_OP_SE256,
					SFD_OP_CHIP: begin
						// refused: kind/address kept
						if (wel_r) begin
							op_start_r <= 1'b1;
							op_kind_r  <= kind_r;
							op_addr_r  <= addr_r;
						end
					end
					SFD_OP_EVAL, SFD_OP_ECNT: begin
						op_start_r <= 1'b1;
						op_kind_r  <= kind_r;
						op_addr_r  <= addr_r;
					end
					SFD_OP_SUSPA: susp_all_r <= 1'b1;
					SFD_OP_SUSPP: susp_pe_r <= 1'b1;
					default: op_start_r <= 1'b0;
				endcase
			end
		end
	end

	assign op_start = op_start_r;
	assign op_kind  = op_kind_r;
	assign op_addr  = op_addr_r;
	assign susp_all = susp_all_r;
	assign susp_pe  = susp_pe_r;
	assign wr_drop  = wr_drop_r;
endmodule

/* File: rtl/sfd_pkg.sv */
// shared constants for the flash program/erase command link
package sfd_pkg;
	localparam logic [7:0] OP_WREN      = 8'h06;
	localparam logic [7:0] OP_PP4       = 8'h12;
	localparam logic [7:0] OP_SE4K3     = 8'h20;
	localparam logic [7:0] OP_SE4K4     = 8'h21;
	localparam logic [7:0] OP_SE256K3   = 8'hD8;
	localparam logic [7:0] OP_SE256K4   = 8'hDC;
	localparam logic [7:0] OP_CE_A      = 8'h60;
	localparam logic [7:0] OP_CE_B      = 8'hC7;
	localparam logic [7:0] OP_EVAL3     = 8'hD0;
	localparam logic [7:0] OP_ECNT3     = 8'h5D;
	localparam logic [7:0] OP_SUSP_ALL  = 8'h75;
	localparam logic [7:0] OP_SUSP_A    = 8'h85;
	localparam logic [7:0] OP_SUSP_B    = 8'hB0;
	localparam logic [2:0] BIT_LAST     = 3'h7;
	localparam logic [2:0] ADDR_BYTES3  = 3'h3;
	localparam logic [2:0] ADDR_BYTES4  = 3'h4;
	localparam logic [2:0] ADDR_BYTES0  = 3'h0;
	localparam int         PAGE_BYTES   = 256;
	localparam int         FIFO_DEPTH   = 16;

	typedef enum logic [3:0] {
		SFD_OP_NONE  = 4'h0,
		SFD_OP_PROG  = 4'h1,
		SFD_OP_SE4K  = 4'h2,
		SFD_OP_SE256 = 4'h3,
		SFD_OP_CHIP  = 4'h4,
		SFD_OP_EVAL  = 4'h5,
		SFD_OP_ECNT  = 4'h6,
		SFD_OP_SUSPA = 4'h7,
		SFD_OP_SUSPP = 4'h8,
		SFD_OP_WREN  = 4'h9
	} sfd_op_t;

	typedef enum logic [1:0] {
		SFD_IDLE = 2'b00,
		SFD_OPC  = 2'b01,
		SFD_ADR  = 2'b11,
		SFD_DAT  = 2'b10
	} sfd_st_t;
endpackage

/* File: rtl/sfd_if.sv */
// single-line serial link between host and flash decoder
`timescale 1ns/1ps
interface sfd_if;
	logic sck;
	logic cs_b;
	logic sdi;
	modport host (output sck, output cs_b, output sdi);
	modport dev  (input sck, input cs_b, input sdi);
endinterface

/* File: rtl/sfd_fifo.sv */
// parameterised valid/ready FIFO
`timescale 1ns/1ps
module sfd_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             sys_clk,
	input  wire logic             rst_b,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wp_r;
	logic [AW-1:0]    rp_r;
	logic [AW:0]      cnt_r;
	logic             push;
	logic             pop;

	assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign out_data  = mem[rp_r];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge sys_clk) begin
		if (push)
			mem[wp_r] <= in_data;
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (push)
				wp_r <= wp_r + 1'b1;
			if (pop)
				rp_r <= rp_r + 1'b1;
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

/* File: rtl/sfd_host.sv */
// host end: serialises one flash transaction per request
`timescale 1ns/1ps
module sfd_host
	import sfd_pkg::*;
#(
	parameter int DIV = 4
) (
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	sfd_if.host              link,
	input  wire logic        req,
	input  wire logic [7:0]  req_op,
	input  wire logic [31:0] req_addr,
	input  wire logic [2:0]  req_abytes,
	input  wire logic [7:0]  data_in,
	input  wire logic        data_valid,
	output logic             data_ready,
	output logic             busy
);
	import sfd_pkg::*;

	logic [7:0]  sh_r;
	logic [2:0]  bit_r;
	logic [2:0]  left_r;
	logic [31:0] addr_r;
	logic        act_r;
	logic        sck_r;
	logic        cs_r;
	logic [7:0]  div_r;
	logic        dready_r;
	logic        tick;

	assign tick = (div_r == 8'(DIV - 1));

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			div_r <= '0;
		else
			div_r <= tick ? '0 : div_r + 1'b1;
	end

	// opcode, address msb first, then page data
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			act_r    <= 1'b0;
			cs_r     <= 1'b1;
			sck_r    <= 1'b0;
			sh_r     <= '0;
			bit_r    <= '0;
			left_r   <= '0;
			addr_r   <= '0;
			dready_r <= 1'b0;
		end else begin
			dready_r <= 1'b0;
			if (!act_r) begin
				if (req) begin
					act_r  <= 1'b1;
					cs_r   <= 1'b0;
					sh_r   <= req_op;
					left_r <= req_abytes;
					addr_r <= req_addr << (8 * (4 - 32'(req_abytes)));
					bit_r  <= '0;
				end
			end else if (tick) begin
				if (!sck_r) begin
					sck_r <= 1'b1;
				end else begin
					sck_r <= 1'b0;
					bit_r <= bit_r + 1'b1;
					sh_r  <= {sh_r[6:0], 1'b0};
					if (bit_r == BIT_LAST) begin
						if (left_r != '0) begin
							sh_r   <= addr_r[31:24];
							addr_r <= {addr_r[23:0], 8'h00};
							left_r <= left_r - 1'b1;
						end else if (data_valid) begin
							sh_r     <= data_in;
							dready_r <= 1'b1;
						end else begin
							act_r <= 1'b0;
							cs_r  <= 1'b1;
						end
					end
				end
			end
		end
	end

	assign link.sck   = sck_r;
	assign link.cs_b  = cs_r;
	assign link.sdi   = sh_r[7];
	assign data_ready = dready_r;
	assign busy       = act_r;
endmodule

/* File: verif/sfd_link_checker.sv */
// wire-level checks on the host-to-decoder link
`timescale 1ns/1ps
module sfd_link_checker
	import sfd_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic sck,
	input wire logic cs_b,
	input wire logic sdi
);
	logic [11:0] cnt_r;
	logic [7:0]  sh_r;
	logic [7:0]  op_r;
	logic        sck_d_r;

	// bit count and first byte of the current frame
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_r   <= '0;
			sh_r    <= '0;
			op_r    <= '0;
			sck_d_r <= 1'b0;
		end else begin
			sck_d_r <= sck;
			if (cnt_r == 12'h008)
				op_r <= sh_r;
			if (cs_b)
				cnt_r <= '0;
			else if (sck && !sck_d_r) begin
				cnt_r <= cnt_r + 12'h001;
				sh_r  <= {sh_r[6:0], sdi};
			end
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	chk_sck_idle: assert property (cs_b |-> !sck)
		else $error("sck moved while deselected");
	chk_sdi_hold: assert property (sck && $past(sck) |-> $stable(sdi))
		else $error("sdi changed while sck high");
	chk_sck_high: assert property ($rose(sck) |-> sck[*4] ##1 !sck)
		else $error("sck high phase wrong");
	chk_sck_low: assert property ($fell(sck) |-> !sck[*4])
		else $error("sck low phase short");
	chk_first_edge: assert property ($fell(cs_b) |-> ##[1:8] $rose(sck))
		else $error("no sck after select");
	chk_whole_bytes: assert property ($rose(cs_b) |-> cnt_r[2:0] == 3'h0)
		else $error("frame not whole bytes");
	chk_prog_len: assert property ($rose(cs_b) && op_r == OP_PP4
		|-> cnt_r >= 12'h028) else $error("program frame short");
	chk_small_len: assert property ($rose(cs_b) && op_r == OP_SE4K3
		|-> cnt_r == 12'h020) else $error("small erase length");
	chk_large_len: assert property ($rose(cs_b) && op_r == OP_SE256K4
		|-> cnt_r == 12'h028) else $error("large erase length");
	chk_chip_len: assert property ($rose(cs_b) && op_r == OP_CE_B
		|-> cnt_r == 12'h008) else $error("chip erase length");
	chk_susp_len: assert property ($rose(cs_b) && op_r == OP_SUSP_B
		|-> cnt_r == 12'h008) else $error("suspend length");
endmodule

/* File: verif/serial_flash_program_erase_decoder_tb_top.sv */
// bench: host and decoder joined over the link, scoreboarded
`timescale 1ns/1ps
`define CHK(w, e, g) begin n_tests++; if ((e) !== (g)) begin \
	mismatches++; $display("ERROR %s exp %h got %h", w, e, g); end end
module serial_flash_program_erase_decoder_tb_top;
	import sfd_pkg::*;
	logic        sys_clk, rst_b, req, data_valid, wr_ready;
	logic        data_ready, busy, op_start, susp_all, susp_pe;
	logic        wr_valid, wr_drop;
	logic [7:0]  req_op, data_in, wr_data, d;
	logic [7:0]  pd [20];
	logic [31:0] req_addr, op_addr;
	logic [2:0]  req_abytes;
	sfd_op_t     op_kind;
	logic [36:0] exp_q [$];
	logic [36:0] e;
	logic [3:0]  ks;
	logic [7:0]  dq [$];
	int          mismatches, n_tests, drops, seed, j;
	logic [7:0]  eop [6] = '{OP_SE4K3, OP_SE4K4, OP_SE256K3,
		OP_SE256K4, OP_CE_A, OP_CE_B};
	logic [2:0]  enb [6] = '{3'h3, 3'h4, 3'h3, 3'h4, 3'h0, 3'h0};
	sfd_op_t     ek [6] = '{SFD_OP_SE4K, SFD_OP_SE4K, SFD_OP_SE256,
		SFD_OP_SE256, SFD_OP_CHIP, SFD_OP_CHIP};

	sfd_if lnk();
	sfd_host i_sfd_host (.sys_clk(sys_clk), .rst_b(rst_b), .link(lnk),
		.req(req), .req_op(req_op), .req_addr(req_addr),
		.req_abytes(req_abytes), .data_in(data_in),
		.data_valid(data_valid), .data_ready(data_ready), .busy(busy));
	sfd_dev i_sfd_dev (.sys_clk(sys_clk), .rst_b(rst_b), .link(lnk),
		.op_start(op_start), .op_kind(op_kind), .op_addr(op_addr),
		.susp_all(susp_all), .susp_pe(susp_pe), .wr_data(wr_data),
		.wr_valid(wr_valid), .wr_ready(wr_ready), .wr_drop(wr_drop));
	sfd_link_checker i_sfd_link_checker (.sys_clk(sys_clk),
		.rst_b(rst_b), .sck(lnk.sck), .cs_b(lnk.cs_b), .sdi(lnk.sdi));

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// one frame; notes the launch and kept page bytes it should cause
	task automatic xfer(input logic [7:0] op, input logic [2:0] nb,
		input int nd, input sfd_op_t k);
		logic [31:0] a;
		int          i;
		a = $random(seed);
		a = (nb == 3'h4) ? a : {8'h00, a[23:0]};
		for (i = 0; i < nd; i++) begin
			pd[i] = 8'($random(seed));
			// fifo keeps only its 16 words while stalled
			if (k != SFD_OP_NONE && i < 16)
				dq.push_back(pd[i]);
		end
		if (k != SFD_OP_NONE)
			exp_q.push_back({nb != 3'h0, k, a});
		req        <= 1'b1;
		req_op     <= op;
		req_addr   <= a;
		req_abytes <= nb;
		data_in    <= pd[0];
		data_valid <= nd > 0;
		@(posedge sys_clk);
		while (!busy) @(posedge sys_clk);
		req <= 1'b0;
		i = 0;
		while (busy) begin
			@(posedge sys_clk);
			if (data_ready) begin
				i++;
				data_in    <= pd[i % 20];
				data_valid <= i < nd;
			end
		end
	endtask

	always @(posedge sys_clk) begin
		if (op_start || susp_all || susp_pe) begin
			e = exp_q.size() ? exp_q.pop_front() : '1;
			ks = susp_all ? SFD_OP_SUSPA :
				(susp_pe ? SFD_OP_SUSPP : op_kind);
			`CHK("kind", e[35:32], ks)
			if (e[36]) `CHK("addr", e[31:0], op_addr)
		end
		if (wr_valid && wr_ready) begin
			d = dq.size() ? dq.pop_front() : 8'hxx;
			`CHK("data", d, wr_data)
		end
		if (wr_drop)
			drops++;
	end

	initial begin
		seed       = 32'h0000_936d;
		rst_b      = 1'b0;
		req        = 1'b0;
		req_op     = '0;
		req_addr   = '0;
		req_abytes = '0;
		data_in    = '0;
		data_valid = 1'b0;
		wr_ready   = 1'b1;
		repeat (16) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		xfer(OP_PP4, 3'h4, 2, SFD_OP_NONE);
		xfer(OP_SE4K3, 3'h3, 0, SFD_OP_NONE);
		xfer(8'hab, 3'h0, 0, SFD_OP_NONE);
		`CHK("held", SFD_OP_NONE, op_kind)
		$display("done: refusal");
		for (j = 0; j < 6; j++) begin
			xfer(OP_WREN, 3'h0, 0, SFD_OP_NONE);
			xfer(eop[j], enb[j], 0, ek[j]);
		end
		xfer(OP_SE256K3, 3'h3, 0, SFD_OP_NONE);
		$display("done: erase");
		xfer(OP_EVAL3, 3'h3, 0, SFD_OP_EVAL);
		xfer(OP_ECNT3, 3'h3, 0, SFD_OP_ECNT);
		xfer(OP_SUSP_ALL, 3'h0, 0, SFD_OP_SUSPA);
		xfer(OP_SUSP_A, 3'h0, 0, SFD_OP_SUSPP);
		xfer(OP_SUSP_B, 3'h0, 0, SFD_OP_SUSPP);
		$display("done: query and suspend");
		xfer(OP_WREN, 3'h0, 0, SFD_OP_NONE);
		xfer(OP_PP4, 3'h4, 4, SFD_OP_PROG);
		wr_ready <= 1'b0;
		xfer(OP_WREN, 3'h0, 0, SFD_OP_NONE);
		xfer(OP_PP4, 3'h4, 20, SFD_OP_PROG);
		repeat (8) @(posedge sys_clk);
		`CHK("drops", 4, drops)
		wr_ready <= 1'b1;
		repeat (40) @(posedge sys_clk);
		`CHK("left", 0, dq.size() + exp_q.size())
		$display("done: page program");
		tally_and_finish();
	end

	initial begin
		repeat (60000) @(posedge sys_clk);
		mismatches++;
		tally_and_finish();
	end
endmodule
